// [shared/timer_compare_defines.svh]
/*
 * Constants of the timer compare channel: register offsets, field positions,
 * reset values and compare mode codes.
 * Assumes inclusion by bare name from the package and the core module.
 */
// Overview of operation
// - Compare 16-bit compare_value_pair with 16-bit timer_count_pair continuously; act per mode.
// - Any match in a mode other than 0000 sets compare_match_flag together with the pin action.
// - Second channel output may move to an alternate pin by alt_pin_function_reg.
// - All-zero compare_control_reg forces the compare output latch low.
// - Mode 1010 only flags matches; pin stays untouched.
// - Mode 1011 match resets timer and starts conversion if converter enabled.
// - Conversion trigger fires at match; timer clears at next timer clock edge.
// - Compare-caused timer reset never sets timer_overflow_flag.
// - If match vanishes before the timer-clear edge, no timer reset happens.
// - No compare action while the system clock sleeps.
`ifndef TIMER_COMPARE_DEFINES_SVH
`define TIMER_COMPARE_DEFINES_SVH

`define TC_ADDR_W      8
`define TC_CNT_W       16
`define TC_MODE_W      4
`define TC_FLAG_W      2
`define TC_DIR_W       2

// Register byte offsets
`define TC_OFS_CTRL    8'h00
`define TC_OFS_VALUE   8'h04
`define TC_OFS_FLAGS   8'h08
`define TC_OFS_MASK    8'h0c
`define TC_OFS_ALTPIN  8'h10
`define TC_OFS_DIR     8'h14
`define TC_OFS_STATE   8'h18

// Flag, state and direction bit positions
`define TC_FLAG_MATCH  0
`define TC_FLAG_OVF    1
`define TC_ST_LATCH    0
`define TC_ST_EQUAL    1
`define TC_ST_RSTREQ   2
`define TC_DIR_MAIN    0
`define TC_DIR_ALT     1

// Reset values
`define TC_RST_MODE    4'h0
`define TC_RST_VALUE   16'h0000
`define TC_RST_FLAGS   2'h0
`define TC_RST_MASK    2'h0
`define TC_RST_DIR     2'h3

// Compare mode codes
`define TC_MODE_OFF    4'h0
`define TC_MODE_TOGGLE 4'h2
`define TC_MODE_SET    4'h8
`define TC_MODE_CLEAR  4'h9
`define TC_MODE_SWINT  4'ha
`define TC_MODE_TRIG   4'hb

// AXI responses
`define TC_RESP_OKAY   2'h0
`define TC_RESP_SLVERR 2'h2

`endif

// [shared/timer_compare_pkg.sv]
/*
 * Types of the timer compare channel: the packed state of the core.
 * Assumes timer_compare_defines.svh is on the include path.
 */
`include "timer_compare_defines.svh"

package timer_compare_pkg;

  typedef logic [`TC_CNT_W-1:0] count_t;

  typedef struct packed {
    logic                   aw_got;
    logic [`TC_ADDR_W-1:0]  awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [`TC_MODE_W-1:0]  mode;
    count_t                 value;
    logic [`TC_FLAG_W-1:0]  flags;
    logic [`TC_FLAG_W-1:0]  mask;
    logic                   alt_sel;
    logic [`TC_DIR_W-1:0]   dir;
    logic                   latch;
    logic                   equal;
    logic                   reset_req;
    logic                   adc_trig;
    logic                   pin_out;
    logic                   pin_oe_b;
    logic                   alt_out;
    logic                   alt_oe_b;
    logic                   irq;
  } state_s;

endpackage : timer_compare_pkg

// [core/timer_compare_unit.sv]
/*
 * Timer compare channel with AXI4-Lite register access, compare output latch,
 * primary and alternate pin drive, conversion trigger and timer clear request.
 * Assumes the timer and converter run on clk_i; timer_tick_i marks the cycle
 * in which the timer advances, and the timer loads zero on a tick while
 * timer_reset_o is high.
 */
`timescale 1ns/1ps
`include "timer_compare_defines.svh"

module timer_compare_unit (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [`TC_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [`TC_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire logic [`TC_CNT_W-1:0]  timer_count_i,
  input  wire logic                  timer_tick_i,
  input  wire logic                  timer_overflow_i,
  input  wire logic                  adc_enable_i,
  input  wire logic                  sleep_i,
  output logic                       timer_reset_o,
  output logic                       adc_trigger_o,
  output logic                       pin_out_o,
  output logic                       pin_oe_b_o,
  output logic                       alt_pin_out_o,
  output logic                       alt_pin_oe_b_o,
  output logic                       irq_o
);

  timer_compare_pkg::state_s s_q;
  timer_compare_pkg::state_s s_d;

  // Returns 1 when the byte address hits a mapped register
  function automatic logic addr_hit(input logic [`TC_ADDR_W-1:0] a);
    unique case (a)
      `TC_OFS_CTRL, `TC_OFS_VALUE, `TC_OFS_FLAGS, `TC_OFS_MASK,
      `TC_OFS_ALTPIN, `TC_OFS_DIR, `TC_OFS_STATE: addr_hit = 1'b1;
      default:                                    addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  // Merges write data into the old word by byte lanes
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge_lanes = m;
  endfunction : merge_lanes

  // Returns the zero-extended current content of a register
  function automatic logic [31:0] reg_word(input timer_compare_pkg::state_s s,
                                           input logic [`TC_ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `TC_OFS_CTRL:   w[`TC_MODE_W-1:0] = s.mode;
      `TC_OFS_VALUE:  w[`TC_CNT_W-1:0] = s.value;
      `TC_OFS_FLAGS:  w[`TC_FLAG_W-1:0] = s.flags;
      `TC_OFS_MASK:   w[`TC_FLAG_W-1:0] = s.mask;
      `TC_OFS_ALTPIN: w[0] = s.alt_sel;
      `TC_OFS_DIR:    w[`TC_DIR_W-1:0] = s.dir;
      `TC_OFS_STATE: begin
        w[`TC_ST_LATCH]  = s.latch;
        w[`TC_ST_EQUAL]  = s.equal;
        w[`TC_ST_RSTREQ] = s.reset_req;
      end
      default:        w = 32'h0000_0000;
    endcase
    reg_word = w;
  endfunction : reg_word

  logic                  do_write;
  logic [31:0]           wr_word;
  logic                  pin_mode;
  logic                  equal_now;
  logic                  match_evt;
  logic [`TC_FLAG_W-1:0] flag_set;
  logic [`TC_FLAG_W-1:0] flag_clr;

  always_comb begin
    s_d       = s_q;
    do_write  = 1'b0;
    wr_word   = 32'h0000_0000;
    flag_set  = `TC_RST_FLAGS;
    flag_clr  = `TC_RST_FLAGS;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid_i && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end

    // Commit once both halves are held and no response is pending
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      do_write   = addr_hit(s_q.awaddr);
      wr_word    = merge_lanes(reg_word(s_q, s_q.awaddr), s_q.wdata, s_q.wstrb);
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = do_write ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end

    if (do_write) begin
      unique case (s_q.awaddr)
        `TC_OFS_CTRL:   s_d.mode    = wr_word[`TC_MODE_W-1:0];
        `TC_OFS_VALUE:  s_d.value   = wr_word[`TC_CNT_W-1:0];
        `TC_OFS_FLAGS:  flag_clr    = wr_word[`TC_FLAG_W-1:0];
        `TC_OFS_MASK:   s_d.mask    = wr_word[`TC_FLAG_W-1:0];
        `TC_OFS_ALTPIN: s_d.alt_sel = wr_word[0];
        `TC_OFS_DIR:    s_d.dir     = wr_word[`TC_DIR_W-1:0];
        default:        s_d.mode    = s_q.mode;
      endcase
    end

    // Read channel: one read at a time, answered the cycle after acceptance
    if (s_axi_arvalid_i && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = reg_word(s_q, s_axi_araddr_i);
      s_d.rresp  = addr_hit(s_axi_araddr_i) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end

    // Compare against the value that stands after this cycle's write
    equal_now = (s_d.value == timer_count_i);
    // Only the rising edge of equality counts, and never in sleep
    match_evt = equal_now && !s_q.equal && !sleep_i;
    s_d.equal = equal_now;

    pin_mode = (s_d.mode == `TC_MODE_TOGGLE) || (s_d.mode == `TC_MODE_SET) ||
               (s_d.mode == `TC_MODE_CLEAR);

    // Compare output latch
    if (s_d.mode == `TC_MODE_OFF) begin
      s_d.latch = 1'b0;
    end else if (match_evt) begin
      unique case (s_d.mode)
        `TC_MODE_TOGGLE: s_d.latch = !s_q.latch;
        `TC_MODE_SET:    s_d.latch = 1'b1;
        `TC_MODE_CLEAR:  s_d.latch = 1'b0;
        default:         s_d.latch = s_q.latch;
      endcase
    end

    // Any active mode flags a match in the cycle of the pin action
    flag_set[`TC_FLAG_MATCH] = match_evt && (s_d.mode != `TC_MODE_OFF);
    // Only the timer's own overflow sets this flag
    flag_set[`TC_FLAG_OVF] = timer_overflow_i;

    // A new event wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;

    // Conversion start goes out at once on the match
    s_d.adc_trig = match_evt && (s_d.mode == `TC_MODE_TRIG) && adc_enable_i;

    // Timer clear request waits for the next timer tick and drops if
    // the match goes away or the mode changes first
    s_d.reset_req = ((match_evt && (s_d.mode == `TC_MODE_TRIG)) ||
                     (s_q.reset_req && !timer_tick_i)) &&
                    equal_now && (s_d.mode == `TC_MODE_TRIG) && !sleep_i;

    // Pin drive; the channel releases the pin outside the latch modes
    s_d.pin_out  = s_d.latch;
    s_d.alt_out  = s_d.latch;
    s_d.pin_oe_b = !(pin_mode && !s_d.alt_sel && !s_d.dir[`TC_DIR_MAIN]);
    s_d.alt_oe_b = !(pin_mode && s_d.alt_sel && !s_d.dir[`TC_DIR_ALT]);

    s_d.irq = |(s_d.flags & s_d.mask);

    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q           <= '0;
      s_q.mode      <= `TC_RST_MODE;
      s_q.value     <= `TC_RST_VALUE;
      s_q.flags     <= `TC_RST_FLAGS;
      s_q.mask      <= `TC_RST_MASK;
      s_q.dir       <= `TC_RST_DIR;
      s_q.pin_oe_b  <= 1'b1;
      s_q.alt_oe_b  <= 1'b1;
      s_q.awready   <= 1'b1;
      s_q.wready    <= 1'b1;
      s_q.arready   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o  = s_q.wready;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rdata_o   = s_q.rdata;
  assign s_axi_rresp_o   = s_q.rresp;
  assign timer_reset_o   = s_q.reset_req;
  assign adc_trigger_o   = s_q.adc_trig;
  assign pin_out_o       = s_q.pin_out;
  assign pin_oe_b_o      = s_q.pin_oe_b;
  assign alt_pin_out_o   = s_q.alt_out;
  assign alt_pin_oe_b_o  = s_q.alt_oe_b;
  assign irq_o           = s_q.irq;

endmodule : timer_compare_unit

// [sim/timer_model.sv]
/* Timer feeding the compare channel, counting on a divided tick.
   Assumes the core clock; the bench may load a count. */
`timescale 1ns/1ps
module timer_model #(
  parameter int TICK_DIV = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clear_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  output logic [15:0]      count_o,
  output logic             tick_o,
  output logic             ovf_o
);
  int div_q;
  assign tick_o = (div_q == TICK_DIV - 1);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q   <= 0;
      count_o <= 16'h0000;
      ovf_o   <= 1'h0;
    end else begin
      div_q <= tick_o ? 0 : div_q + 1;
      ovf_o <= tick_o && !clear_i && count_o == 16'hffff;
      if (load_i) begin
        count_o <= load_val_i;
      end else if (tick_o) begin
        count_o <= clear_i ? 16'h0000 : count_o + 16'h0001;
      end
    end
  end
endmodule : timer_model

// [sim/timer_compare_checker.sv]
/* Assertions on the compare channel outputs.
   Assumes a bind to timer_compare_unit; one clock domain. */
`timescale 1ns/1ps
module timer_compare_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic timer_tick_i,
  input wire logic adc_enable_i,
  input wire logic sleep_i,
  input wire logic timer_reset_o,
  input wire logic adc_trigger_o,
  input wire logic pin_out_o,
  input wire logic pin_oe_b_o,
  input wire logic alt_pin_oe_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence fire_s;
    adc_trigger_o && timer_reset_o;
  endsequence
  sequence tick_clear_s;
    timer_reset_o && timer_tick_i;
  endsequence
  trig_pulse_a:
    assert property (fire_s |=> !adc_trigger_o[*2]) else $error("trigger too long");
  trig_with_clear_a:
    assert property (adc_trigger_o |-> fire_s) else $error("trigger without clear");
  trig_enable_a:
    assert property ($rose(timer_reset_o) |-> adc_trigger_o == $past(adc_enable_i))
      else $error("trigger ignores enable");
  clear_drop_a:
    assert property (tick_clear_s |=> !timer_reset_o) else $error("clear held past tick");
  clear_bound_a:
    assert property ($rose(timer_reset_o) |-> ##[1:12] !timer_reset_o)
      else $error("clear never ends");
  trig_no_pin_a:
    assert property (timer_reset_o |-> pin_oe_b_o && alt_pin_oe_b_o)
      else $error("pin driven in trigger mode");
  sleep_quiet_a:
    assert property ($past(sleep_i) |-> !$rose(timer_reset_o) && !$rose(pin_out_o))
      else $error("action during sleep");
  pin_once_a:
    assert property ($changed(pin_out_o) |=> $stable(pin_out_o)) else $error("pin repeats");
endmodule : timer_compare_checker

// [sim/timer_compare_unit_tb_top.sv]
/* Bench of the compare channel: AXI4-Lite tasks, timer model, checker.
   Assumes the defines header on the include path. */
`timescale 1ns/1ps
`include "timer_compare_defines.svh"
module timer_compare_unit_tb_top;
  logic        clk_i = 0, rst_b_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, adc_en = 0, sleep = 0, load = 0, awready, wready, bvalid;
  logic        arready, rvalid, tick, ovf, clr, trig, pin, pin_oe_b, apin, apin_oe_b, irq;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic [15:0] cnt, load_val = '0;
  int          err_count = 0, checks = 0, trig_n = 0;
  logic [3:0]  pm[5] = '{4'h9, 4'h8, 4'h2, 4'h2, 4'h8};
  logic        pl[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
  logic [31:0] rv[6] = '{0, 0, 0, 0, 0, 3};
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (trig === 1'h1) trig_n++;
  timer_model i_tmr (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr), .load_i(load),
    .load_val_i(load_val), .count_o(cnt), .tick_o(tick), .ovf_o(ovf));
  timer_compare_unit i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer_count_i(cnt), .timer_tick_i(tick),
    .timer_overflow_i(ovf), .adc_enable_i(adc_en), .sleep_i(sleep), .timer_reset_o(clr),
    .adc_trigger_o(trig), .pin_out_o(pin), .pin_oe_b_o(pin_oe_b), .alt_pin_out_o(apin),
    .alt_pin_oe_b_o(apin_oe_b), .irq_o(irq));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 0);
    logic aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk_i);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'h1);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 0);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk_i); while (arready !== 1'h1);
    arvalid <= 0;
    do @(posedge clk_i); while (rvalid !== 1'h1);
    chk("rdata", exp, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 0;
    @(posedge clk_i);
  endtask : rd
  task automatic hit(input logic [15:0] v);
    wr(`TC_OFS_VALUE, 32'(v));
    load <= 1;
    load_val <= v - 16'h0002;
    @(posedge clk_i);
    load <= 0;
    repeat (40) @(posedge clk_i);
  endtask : hit
  task automatic end_sim;
    $display("Counts: checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    foreach (rv[i]) rd(8'(i * 4), rv[i]);
    rd(8'h1c, 0, `TC_RESP_SLVERR);
    wr(8'h1c, 1, `TC_RESP_SLVERR);
    $display("Test registers done");
    wr(`TC_OFS_DIR, 0);
    wr(`TC_OFS_MASK, 1);
    foreach (pm[i]) begin
      wr(`TC_OFS_CTRL, 32'(pm[i]));
      wr(`TC_OFS_FLAGS, 3);
      hit(16'h0100 + 16'(i * 16));
      chk("pin", 32'(pl[i]), 32'(pin));
      chk("pin_oe_b", 0, 32'(pin_oe_b));
      chk("irq", 1, 32'(irq));
    end
    wr(`TC_OFS_MASK, 0);
    chk("irq", 0, 32'(irq));
    wr(`TC_OFS_MASK, 1);
    wr(`TC_OFS_FLAGS, 1);
    chk("irq", 0, 32'(irq));
    wr(`TC_OFS_ALTPIN, 1);
    chk("apin", 1, 32'(apin));
    chk("apin_oe_b", 0, 32'(apin_oe_b));
    chk("pin_oe_b", 1, 32'(pin_oe_b));
    wr(`TC_OFS_CTRL, 0);
    chk("apin", 0, 32'(apin));
    $display("Test pin modes done");
    wr(`TC_OFS_CTRL, 32'(`TC_MODE_SWINT));
    hit(16'h0180);
    chk("apin_oe_b", 1, 32'(apin_oe_b));
    rd(`TC_OFS_FLAGS, 1);
    adc_en <= 1;
    wr(`TC_OFS_FLAGS, 3);
    trig_n = 0;
    wr(`TC_OFS_CTRL, 32'(`TC_MODE_TRIG));
    hit(16'h0200);
    chk("trig_n", 1, 32'(trig_n));
    chk("cleared", 1, 32'(cnt < 16'h0008));
    rd(`TC_OFS_FLAGS, 1);
    adc_en <= 0;
    hit(16'h0200);
    chk("trig_n", 1, 32'(trig_n));
    chk("cleared", 1, 32'(cnt < 16'h0008));
    hit(16'h0300);
    adc_en <= 1;
    hit(16'h0300);
    // Match just after a tick, then move VALUE before the next tick
    do @(posedge clk_i); while (tick !== 1'h1);
    load <= 1;
    load_val <= 16'h0300;
    @(posedge clk_i);
    load <= 0;
    wr(`TC_OFS_VALUE, 32'h0310);
    repeat (12) @(posedge clk_i);
    chk("kept", 1, 32'(cnt > 16'h02ff));
    $display("Test trigger done");
    wr(`TC_OFS_CTRL, 32'(`TC_MODE_SET));
    wr(`TC_OFS_FLAGS, 3);
    sleep <= 1;
    hit(16'h0400);
    chk("apin", 0, 32'(apin));
    rd(`TC_OFS_FLAGS, 0);
    sleep <= 0;
    wr(`TC_OFS_CTRL, 0);
    wr(`TC_OFS_MASK, 2);
    hit(16'h0000);
    rd(`TC_OFS_FLAGS, 2);
    chk("irq", 1, 32'(irq));
    $display("Test sleep and overflow done");
    end_sim();
  end
  initial begin
    #200us;
    err_count++;
    end_sim();
  end
endmodule : timer_compare_unit_tb_top
bind timer_compare_unit timer_compare_checker i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .timer_tick_i(timer_tick_i), .adc_enable_i(adc_enable_i), .sleep_i(sleep_i),
  .timer_reset_o(timer_reset_o), .adc_trigger_o(adc_trigger_o), .pin_out_o(pin_out_o),
  .pin_oe_b_o(pin_oe_b_o), .alt_pin_oe_b_o(alt_pin_oe_b_o));
